/* src/core_ctl_pkg.sv */
package core_ctl_pkg;
    localparam int unsigned PC_W = 13;
    localparam int unsigned STACK_DEPTH = 8;
    localparam int unsigned FA_W = 9;
    // Special function register addresses in the core data map.
    localparam logic [8:0] SFR_INDIRECT = 9'h000;
    localparam logic [8:0] SFR_PC_LOW = 9'h002;
    localparam logic [8:0] SFR_STATUS = 9'h003;
    localparam logic [8:0] SFR_FILE_PTR = 9'h004;
    localparam logic [8:0] SFR_PC_HIGH = 9'h00A;
    localparam logic [8:0] SFR_INT_CTL = 9'h00B;
    localparam logic [8:0] SFR_PIRQ_FLAGS = 9'h00C;
    localparam logic [8:0] SFR_INT_CTL_B1 = 9'h08B;
    localparam logic [8:0] SFR_PIRQ_EN = 9'h08C;
    localparam logic [8:0] SFR_RESET_CAUSE = 9'h08E;
    // APB byte addresses: data address times four.
    localparam logic [11:0] APB_ADDR_MASK = 12'h7FC;
    localparam int unsigned APB_ADDR_LSB = 2;
    // Bank-select-high bit position inside status.
    localparam int unsigned STATUS_BANK_HI = 7;
    // Interrupt control field positions.
    localparam int unsigned IC_GIE = 7;
    localparam int unsigned IC_PERIPH_IRQ_ENABLE = 6;
    localparam int unsigned IC_TIMER_OVF_IRQ_ENABLE = 5;
    localparam int unsigned IC_INTE = 4;
    localparam int unsigned IC_PORT_CHANGE_IRQ_ENABLE = 3;
    localparam int unsigned IC_TIMER_OVF_FLAG = 2;
    localparam int unsigned IC_EXT_PIN_IRQ_FLAG = 1;
    localparam int unsigned IC_PORT_CHANGE_FLAG = 0;
    // Comparator enable and flag sit in bit 6 of their registers.
    localparam int unsigned PIRQ_CMP = 6;
    // Reset cause bits.
    localparam int unsigned RC_POR = 1;
    localparam int unsigned RC_BOR = 0;
    localparam int unsigned RC_WDT = 2;
    localparam int unsigned RC_MASTER_CLEAR_PIN = 3;
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] STACK_PTR_RESET = 8'h00;

    typedef enum logic [2:0] {
        PC_HOLD,
        PC_INC,
        PC_JUMP,
        PC_CALL,
        PC_RETURN,
        PC_VECTOR
    } pc_op_t;

    typedef struct packed {
        pc_op_t op;
        logic [10:0] target;
    } pc_cmd_t;

    typedef struct packed {
        logic timer_ovf;
        logic ext_pin;
        logic comparator;
        logic [3:0] upper_port_pins;
        logic port_read;
    } irq_events_t;

    typedef struct packed {
        logic por;
        logic master_clear_pin;
        logic wdt;
        logic bor;
    } reset_cause_t;
endpackage

/* src/core_irq_pc_stack_control.sv */
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module core_irq_pc_stack_control
    import core_ctl_pkg::*;
#(
    parameter int unsigned STACK_ENTRIES = STACK_DEPTH
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire pc_cmd_t pc_cmd_i,
    input wire irq_events_t events_i,
    input wire reset_cause_t cause_i,
    input wire logic cause_valid_i,
    input wire logic [7:0] ram_rdata_i,
    output logic [FA_W-1:0] ram_addr_o,
    output logic ram_we_o,
    output logic ram_re_o,
    output logic [7:0] ram_wdata_o,
    output logic [PC_W-1:0] pc_o,
    output logic irq_o
);
    localparam int unsigned SP_W = $clog2(STACK_ENTRIES);

    // The circular pointer wraps only at the fixed stack depth.
    if (STACK_ENTRIES != STACK_DEPTH) begin : g_bad_depth
        $error("STACK_ENTRIES must equal STACK_DEPTH");
    end

    logic [7:0] int_ctl_q;
    logic [7:0] pirq_flags_q;
    logic [7:0] pirq_en_q;
    logic [7:0] reset_cause_q;
    logic [7:0] pc_high_q;
    logic [7:0] file_ptr_q;
    logic [7:0] status_q;
    logic [PC_W-1:0] pc_q;
    logic [PC_W-1:0] stack_q [STACK_ENTRIES];
    logic [SP_W-1:0] sp_q;
    logic [3:0] port_prev_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic [FA_W-1:0] ram_addr_q;
    logic ram_we_q;
    logic ram_re_q;
    logic [7:0] ram_wdata_q;
    logic ram_pending_q;

    logic [8:0] reg_addr;
    logic setup;
    logic wr;
    logic [7:0] wbyte;
    logic indirect;
    logic [8:0] eff_addr;
    logic mapped;
    logic [7:0] rdata_d;

    assign setup = psel_i && !penable_i;
    assign reg_addr = 9'((paddr_i & APB_ADDR_MASK) >> APB_ADDR_LSB);
    assign indirect = (reg_addr == SFR_INDIRECT);
    // Bank bit above the 8-bit pointer; unused in this map but carried.
    assign eff_addr = indirect ? {status_q[STATUS_BANK_HI], file_ptr_q} : reg_addr;
    assign wbyte = pwdata_i[7:0];
    assign wr = psel_i && penable_i && pwrite_i && pready_q && !pslverr_q;

    always_comb begin
        mapped = 1'b1;
        rdata_d = RESET_ZERO;
        unique case (eff_addr)
            SFR_INT_CTL, SFR_INT_CTL_B1: rdata_d = int_ctl_q;
            SFR_PIRQ_FLAGS: rdata_d = pirq_flags_q;
            SFR_PIRQ_EN: rdata_d = pirq_en_q;
            SFR_RESET_CAUSE: rdata_d = reset_cause_q;
            SFR_PC_LOW: rdata_d = pc_q[7:0];
            SFR_PC_HIGH: rdata_d = pc_high_q;
            SFR_FILE_PTR: rdata_d = file_ptr_q;
            SFR_STATUS: rdata_d = status_q;
            SFR_INDIRECT: rdata_d = RESET_ZERO;
            default: begin
                mapped = indirect;
                rdata_d = RESET_ZERO;
            end
        endcase
    end

    // Access phase: mapped SFRs answer with no wait state; indirect RAM needs one.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
            ram_pending_q <= 1'b0;
            ram_addr_q <= '0;
            ram_we_q <= 1'b0;
            ram_re_q <= 1'b0;
            ram_wdata_q <= RESET_ZERO;
        end else begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ram_we_q <= 1'b0;
            ram_re_q <= 1'b0;
            if (setup) begin
                if (indirect && !mapped_sfr(eff_addr) && eff_addr != SFR_INDIRECT) begin
                    ram_addr_q <= eff_addr;
                    ram_re_q <= !pwrite_i;
                    ram_we_q <= pwrite_i;
                    ram_wdata_q <= wbyte;
                    ram_pending_q <= 1'b1;
                end else begin
                    pready_q <= 1'b1;
                    pslverr_q <= !mapped;
                    prdata_q <= {24'h000000, rdata_d};
                end
            end else if (ram_pending_q) begin
                ram_pending_q <= 1'b0;
                pready_q <= 1'b1;
                prdata_q <= {24'h000000, ram_rdata_i};
            end
        end
    end

    function automatic logic mapped_sfr(input logic [8:0] a);
        mapped_sfr = (a == SFR_INT_CTL) || (a == SFR_INT_CTL_B1) || (a == SFR_PIRQ_FLAGS) ||
            (a == SFR_PIRQ_EN) || (a == SFR_RESET_CAUSE) || (a == SFR_PC_LOW) ||
            (a == SFR_PC_HIGH) || (a == SFR_FILE_PTR) || (a == SFR_STATUS);
    endfunction

    logic port_changed;
    assign port_changed = (events_i.upper_port_pins != port_prev_q);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_prev_q <= 4'h0;
        end else if (events_i.port_read) begin
            port_prev_q <= events_i.upper_port_pins;
        end
    end

    // Hardware set wins over a software clear in the same cycle.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_ctl_q <= RESET_ZERO;
        end else begin
            if (wr && (eff_addr == SFR_INT_CTL || eff_addr == SFR_INT_CTL_B1)) begin
                int_ctl_q <= wbyte;
            end
            if (events_i.timer_ovf) begin
                int_ctl_q[IC_TIMER_OVF_FLAG] <= 1'b1;
            end
            if (events_i.ext_pin) begin
                int_ctl_q[IC_EXT_PIN_IRQ_FLAG] <= 1'b1;
            end
            if (port_changed) begin
                int_ctl_q[IC_PORT_CHANGE_FLAG] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pirq_flags_q <= RESET_ZERO;
            pirq_en_q <= RESET_ZERO;
        end else begin
            if (wr && eff_addr == SFR_PIRQ_EN) begin
                pirq_en_q <= wbyte;
            end
            if (wr && eff_addr == SFR_PIRQ_FLAGS) begin
                pirq_flags_q <= wbyte;
            end
            if (events_i.comparator) begin
                pirq_flags_q[PIRQ_CMP] <= 1'b1;
            end
        end
    end

    // Cause bits are loaded from the reset controller after release.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reset_cause_q <= RESET_ZERO;
        end else if (cause_valid_i) begin
            reset_cause_q[RC_POR] <= !cause_i.por;
            reset_cause_q[RC_WDT] <= !cause_i.wdt;
            reset_cause_q[RC_MASTER_CLEAR_PIN] <= cause_i.master_clear_pin;
            // Left unchanged except by brown-out or software.
            if (cause_i.bor) begin
                reset_cause_q[RC_BOR] <= 1'b0;
            end
        end else if (wr && eff_addr == SFR_RESET_CAUSE) begin
            reset_cause_q[RC_POR] <= wbyte[RC_POR];
            reset_cause_q[RC_BOR] <= wbyte[RC_BOR];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_high_q <= RESET_ZERO;
            file_ptr_q <= RESET_ZERO;
            status_q <= RESET_ZERO;
        end else begin
            if (wr && eff_addr == SFR_PC_HIGH) begin
                pc_high_q <= wbyte;
            end
            if (wr && eff_addr == SFR_FILE_PTR) begin
                file_ptr_q <= wbyte;
            end
            if (wr && eff_addr == SFR_STATUS) begin
                status_q <= wbyte;
            end
        end
    end

    logic [PC_W-1:0] pc_inc;
    logic [SP_W-1:0] sp_pop;
    assign pc_inc = pc_q + 13'd1;
    assign sp_pop = sp_q - 1'b1;

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_q <= '0;
        end else if (wr && eff_addr == SFR_PC_LOW) begin
            pc_q <= {pc_high_q[4:0], wbyte};
        end else begin
            unique case (pc_cmd_i.op)
                PC_HOLD: pc_q <= pc_q;
                PC_INC: pc_q <= pc_inc;
                PC_JUMP, PC_CALL: pc_q <= {pc_high_q[4:3], pc_cmd_i.target};
                PC_RETURN: pc_q <= stack_q[sp_pop];
                PC_VECTOR: pc_q <= {2'b00, pc_cmd_i.target};
                default: pc_q <= pc_q;
            endcase
        end
    end

    // Pointer wraps modulo the depth; no overflow flag exists.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sp_q <= '0;
        end else if (pc_cmd_i.op == PC_CALL || pc_cmd_i.op == PC_VECTOR) begin
            sp_q <= sp_q + 1'b1;
        end else if (pc_cmd_i.op == PC_RETURN) begin
            sp_q <= sp_pop;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (pc_cmd_i.op == PC_CALL) begin
            stack_q[sp_q] <= pc_inc;
        end else if (pc_cmd_i.op == PC_VECTOR) begin
            stack_q[sp_q] <= pc_q;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= int_ctl_q[IC_GIE] && (
                (int_ctl_q[IC_TIMER_OVF_IRQ_ENABLE] && int_ctl_q[IC_TIMER_OVF_FLAG]) ||
                (int_ctl_q[IC_INTE] && int_ctl_q[IC_EXT_PIN_IRQ_FLAG]) ||
                (int_ctl_q[IC_PORT_CHANGE_IRQ_ENABLE] && int_ctl_q[IC_PORT_CHANGE_FLAG]) ||
                (int_ctl_q[IC_PERIPH_IRQ_ENABLE] && pirq_en_q[PIRQ_CMP] && pirq_flags_q[PIRQ_CMP]));
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign ram_addr_o = ram_addr_q;
    assign ram_we_o = ram_we_q;
    assign ram_re_o = ram_re_q;
    assign ram_wdata_o = ram_wdata_q;
    assign pc_o = pc_q;
    assign irq_o = irq_q;
endmodule
`default_nettype wire

/* tb/core_ctl_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module core_ctl_checker
    import core_ctl_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic pready_o,
    input wire pc_cmd_t pc_cmd_i,
    input wire logic ram_re_o,
    input wire logic ram_we_o,
    input wire logic [PC_W-1:0] pc_o,
    input wire logic irq_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    logic ind;
    logic pcl_wr;
    assign ind = paddr_i[10:2] == SFR_INDIRECT;
    assign pcl_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i[10:2] == SFR_PC_LOW;
    sequence s_goto;
        pc_cmd_i.op inside {PC_JUMP, PC_CALL} && !pcl_wr;
    endsequence
    sequence s_vector;
        pc_cmd_i.op == PC_VECTOR && !pcl_wr;
    endsequence
    property p_reset_pc;
        $rose(rst_b_i) |-> pc_o == '0;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");
    property p_pcl_write;
        pcl_wr |=> pc_o[7:0] == $past(pwdata_i[7:0]);
    endproperty
    a_pcl_write: assert property (p_pcl_write) else $error("low byte not loaded");
    property p_goto;
        s_goto |=> pc_o[10:0] == $past(pc_cmd_i.target);
    endproperty
    a_goto: assert property (p_goto) else $error("jump target not loaded");
    property p_vector;
        s_vector |=> pc_o == {2'b00, $past(pc_cmd_i.target)};
    endproperty
    a_vector: assert property (p_vector) else $error("vector target not loaded");
    property p_irq_sticky;
        irq_o && !psel_i && !$past(psel_i) |=> irq_o;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("request dropped alone");
    property p_ram_read;
        ram_re_o |-> psel_i && !pwrite_i && ind;
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("stray ram read");
    property p_ram_write;
        ram_we_o |-> psel_i && pwrite_i && ind;
    endproperty
    a_ram_write: assert property (p_ram_write) else $error("stray ram write");
    property p_pready_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
endmodule
bind core_irq_pc_stack_control core_ctl_checker u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .pc_cmd_i(pc_cmd_i), .ram_re_o(ram_re_o),
    .ram_we_o(ram_we_o), .pc_o(pc_o), .irq_o(irq_o));
`default_nettype wire

/* tb/tb_core_irq_pc_stack_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_core_irq_pc_stack_control
    import core_ctl_pkg::*;
    ;
    logic mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, ram_we_o, ram_re_o;
    logic irq_o, er, cause_valid_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [7:0] ram_rdata_i, ram_wdata_o, wdat, h, v;
    logic [8:0] ram_addr_o, waddr;
    logic [12:0] pc_o, mpc;
    pc_cmd_t pc_cmd_i;
    irq_events_t events_i;
    reset_cause_t cause_i;
    int num_errors = 0, n_tests = 0, sp = 0, nwe = 0;
    int stk [8];
    core_irq_pc_stack_control uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pc_cmd_i(pc_cmd_i),
        .events_i(events_i), .cause_i(cause_i), .cause_valid_i(cause_valid_i),
        .ram_rdata_i(ram_rdata_i),
        .ram_addr_o(ram_addr_o), .ram_we_o(ram_we_o), .ram_re_o(ram_re_o),
        .ram_wdata_o(ram_wdata_o), .pc_o(pc_o), .irq_o(irq_o));
    initial begin
        mclk_i = 1'b0;
        forever #20 mclk_i = ~mclk_i;
    end
    // The RAM answers while its read strobe stands, as the design samples it then.
    assign ram_rdata_i = ram_re_o ? ~ram_addr_o[7:0] : 8'h00;
    always @(posedge mclk_i) begin
        if (ram_we_o === 1'b1) begin
            waddr <= ram_addr_o;
            wdat <= ram_wdata_o;
            nwe <= nwe + 1;
        end
    end
    task automatic conclude();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        num_errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask
    task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) fail($sformatf("reg got %h exp %h", g, e));
    endtask
    task automatic chk_pc(input logic [12:0] e);
        @(negedge mclk_i);
        n_tests++;
        if (pc_o !== e) fail($sformatf("pc got %h exp %h", pc_o, e));
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        n_tests++;
        if (irq_o !== e) fail($sformatf("irq got %b exp %b", irq_o, e));
    endtask
    task automatic apb(input logic w, input logic [8:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {1'b0, a, 2'b00};
        pwdata_i <= {24'h0, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic cause(input reset_cause_t c, input logic [7:0] e);
        @(posedge mclk_i);
        cause_i <= c;
        cause_valid_i <= 1'b1;
        @(posedge mclk_i);
        cause_valid_i <= 1'b0;
        apb(1'b0, SFR_RESET_CAUSE, 8'h00);
        chk_reg(rd[7:0], e);
    endtask
    task automatic push(input logic [12:0] x);
        stk[sp] = x;
        sp = (sp + 1) % 8;
    endtask
    task automatic pcop(input pc_op_t op, input logic [10:0] t);
        @(posedge mclk_i);
        pc_cmd_i <= '{op, t};
        @(posedge mclk_i);
        pc_cmd_i <= '{PC_HOLD, 11'h0};
        if (op == PC_RETURN) begin
            sp = (sp + 7) % 8;
            mpc = 13'(stk[sp]);
        end else if (op == PC_VECTOR) begin
            push(mpc);
            mpc = {2'b00, t};
        end else if (op == PC_INC) begin
            mpc = 13'(mpc + 1);
        end else begin
            if (op == PC_CALL) push(13'(mpc + 1));
            mpc = {h[4:3], t};
        end
        chk_pc(mpc);
    endtask
    initial begin
        #200000;
        fail("timeout");
        conclude();
    end
    initial begin
        int n;
        {rst_b_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, cause_valid_i} = '0;
        cause_i = '0;
        pc_cmd_i = '{PC_HOLD, 11'h0};
        events_i = '0;
        void'($urandom(78843));
        repeat (12) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        chk_pc(13'h0);
        for (int i = 0; i < 3; i++) begin
            @(posedge mclk_i);
            events_i.timer_ovf <= i == 0;
            events_i.ext_pin <= i == 1;
            if (i == 2) events_i.upper_port_pins <= 4'h1 << $urandom_range(3, 0);
            @(posedge mclk_i);
            events_i.timer_ovf <= 1'b0;
            events_i.ext_pin <= 1'b0;
            events_i.port_read <= i == 2;
            @(posedge mclk_i);
            events_i.port_read <= 1'b0;
            apb(1'b0, SFR_INT_CTL, 8'h00);
            chk_reg(rd[7:0], 8'h04 >> i);
            apb(1'b1, SFR_INT_CTL, 8'h24 >> i);
            chk_irq(1'b0);
            apb(1'b1, SFR_INT_CTL_B1, 8'h80 | (8'h04 >> i));
            chk_irq(1'b0);
            apb(1'b1, SFR_INT_CTL, 8'h80 | (8'h24 >> i));
            chk_irq(1'b1);
            apb(1'b0, SFR_INT_CTL_B1, 8'h00);
            chk_reg(rd[7:0], 8'h80 | (8'h24 >> i));
            apb(1'b1, SFR_INT_CTL, 8'h00);
            chk_irq(1'b0);
        end
        @(posedge mclk_i);
        events_i.comparator <= 1'b1;
        @(posedge mclk_i);
        events_i.comparator <= 1'b0;
        apb(1'b0, SFR_PIRQ_FLAGS, 8'h00);
        chk_reg(rd[7:0] & 8'h40, 8'h40);
        apb(1'b1, SFR_PIRQ_EN, 8'h40);
        apb(1'b1, SFR_INT_CTL, 8'h80);
        chk_irq(1'b0);
        apb(1'b1, SFR_INT_CTL, 8'hC0);
        chk_irq(1'b1);
        apb(1'b1, SFR_INT_CTL, 8'h00);
        apb(1'b1, SFR_PIRQ_FLAGS, 8'h00);
        apb(1'b1, SFR_INT_CTL, 8'hC0);
        chk_irq(1'b0);
        apb(1'b1, SFR_INT_CTL, 8'h00);
        apb(1'b1, 9'h1F0, 8'hFF);
        chk_reg({7'h0, er}, 8'h01);
        apb(1'b1, SFR_RESET_CAUSE, 8'h03);
        apb(1'b0, SFR_RESET_CAUSE, 8'h00);
        chk_reg(rd[7:0], 8'h03);
        cause('{1'b0, 1'b0, 1'b1, 1'b1}, 8'h02);
        cause('{1'b1, 1'b1, 1'b0, 1'b0}, 8'h0C);
        h = 8'($urandom_range(31, 0));
        v = 8'($urandom());
        apb(1'b1, SFR_PC_HIGH, h);
        apb(1'b1, SFR_PC_LOW, v);
        mpc = {h[4:0], v};
        chk_pc(mpc);
        pcop(PC_JUMP, 11'($urandom()));
        pcop(PC_INC, 11'h0);
        for (int i = 0; i < 9; i++) pcop(i == 4 ? PC_VECTOR : PC_CALL, 11'($urandom()));
        for (int i = 0; i < 9; i++) pcop(PC_RETURN, 11'h0);
        apb(1'b0, SFR_PC_HIGH, 8'h00);
        chk_reg(rd[7:0], h);
        v = 8'($urandom_range(127, 32));
        apb(1'b1, SFR_FILE_PTR, v);
        apb(1'b0, SFR_INDIRECT, 8'h00);
        chk_reg(rd[7:0], ~v);
        apb(1'b1, SFR_INDIRECT, h);
        repeat (2) @(posedge mclk_i);
        chk_reg(wdat, h);
        chk_reg(waddr[7:0], v);
        apb(1'b1, SFR_FILE_PTR, 8'h00);
        n = nwe;
        apb(1'b1, SFR_INDIRECT, 8'h5A);
        apb(1'b0, SFR_INDIRECT, 8'h00);
        chk_reg(rd[7:0], 8'h00);
        chk_reg(8'(nwe), 8'(n));
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        chk_pc(13'h0);
        conclude();
    end
endmodule
`default_nettype wire
